// ---- src/usir_params.svh ----
// Purpose: Offsets, field positions, reset values and codes of the UART status/interrupt block
// Assumes: Included by the design files by its bare name
// Notes: Definitions only
//
// Contract
// - Receive-ready sets on character load; clears on buffer read or zero write.
// - Overrun sets when a character lands on an unread one; LSR read clears.
// - Parity-error flag sets on bad parity; LSR read clears it.
// - Framing-error flag sets when the stop bit is sampled at zero.
// - Break flag sets when receive input stays low over a character time.
// - Hold-empty sets on hold-to-shift transfer, clears on hold write, may interrupt.
// - Shift-empty sets while shifter idles, clears on hold-to-shift transfer.
// - Line status bit 7 always reads zero.
// - Overrun, parity, framing or break raise the line status interrupt.
// - Priority: line status, then received data, then hold empty, then modem.
// - Addressing the identification register freezes the shown interrupt.
// - Identification bit 0 is zero when pending, one when none.
// - Identification bits 2:1 are 11, 10, 01, 00 by source.
// - Identification bits 7:3 always read zero.
// - Four enables: data, hold empty, line status, modem; bits 7:4 read zero.
// - All enables cleared inhibits identification and pin; status still updates.
// - Terminal-ready follows control bit 0; low with strap requests command state.
// - Control bits 1 and 2 only held; bits 7:5 read zero. The code also drives send_request and aux1 from bits 1 and 2.
// - Interrupt pin floats whenever control bit 3 is zero.
// - Modem change bits set on input change, cleared by modem status read.
// - Bit 2 sets on ring falling edge; bit 3 on carrier change.
// - Bits 1:0 read zero, 5:4 one, 6 inverted ring, 7 carrier.
// - Ring trailing flag or carrier change raises the modem interrupt when enabled.
`ifndef USIR_PARAMS_SVH
`define USIR_PARAMS_SVH

`define USIR_AW 5
`define USIR_OFF_DATA 5'h00
`define USIR_OFF_IER 5'h04
`define USIR_OFF_IIR 5'h08
`define USIR_OFF_MCR 5'h10
`define USIR_OFF_LSR 5'h14
`define USIR_OFF_MSR 5'h18

`define USIR_LSR_DR 0
`define USIR_LSR_OE 1
`define USIR_LSR_PE 2
`define USIR_LSR_FE 3
`define USIR_LSR_BI 4
`define USIR_LSR_TX_HOLD_EMPTY 5
`define USIR_LSR_TX_SHIFT_EMPTY 6

`define USIR_IER_RDA 0
`define USIR_IER_TX_HOLD_EMPTY 1
`define USIR_IER_RLS 2
`define USIR_IER_MS 3

`define USIR_MCR_DTR 0
`define USIR_MCR_RTS 1
`define USIR_MCR_AUX1 2
`define USIR_MCR_AUX2 3

`define USIR_MSR_RING_TRAILING_EDGE 2
`define USIR_MSR_DCDC 3

`define USIR_ID_NONE 3'h1
`define USIR_ID_RLS 3'h6
`define USIR_ID_RDA 3'h4
`define USIR_ID_TX_HOLD_EMPTY 3'h2
`define USIR_ID_MS 3'h0

`define USIR_IER_RST 4'h0
`define USIR_MCR_RST 5'h00
`define USIR_MSR_ONES 2'h3
`define USIR_SYNC_STAGES 3

`endif

// ---- src/usir_pkg.sv ----
// Purpose: Types shared by the UART status/interrupt block
// Assumes: Nothing beyond the language
// Notes: Constants live in usir_params.svh
package usir_pkg;

   // Receive datapath events, one-cycle pulses
   typedef struct packed {
      logic load;
      logic parity_bad;
      logic stop_zero;
      logic brk;
   } usir_rx_ev_t;

   // Transmit datapath status
   typedef struct packed {
      logic hold_to_shift;
      logic shift_idle;
   } usir_tx_st_t;

   // Modem control outputs
   typedef struct packed {
      logic terminal_ready;
      logic send_request;
      logic aux1;
      logic aux2;
   } usir_mctl_t;

endpackage

// ---- src/usir_sync.sv ----
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Inputs come from outside the clk domain
// Notes: Output moves only once stages two and three agree
module usir_sync #(
   parameter int W = 2
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // Stage one feeds stage two only
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end
      else
      begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // Accept a level once two stages match
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         q <= '0;
      else
         q <= (s2 & s3) | (q & (s2 | s3));
   end
endmodule // usir_sync

// ---- src/usir_flag.sv ----
// Purpose: Sticky status flag
// Assumes: Set and clear are same-clock strobes
// Notes: Set wins over clear so no event is lost
module usir_flag #(
   parameter bit RST_VAL = 1'b0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic set,
   input wire logic clr,
   output logic q
);
   // Set has priority
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         q <= RST_VAL;
      else if (set)
         q <= 1'b1;
      else if (clr)
         q <= 1'b0;
   end
endmodule // usir_flag

// ---- src/usir_top.sv ----
// Purpose: Line status, interrupt identification and modem control/status registers
// Assumes: APB slave, one wait state; receive and transmit datapath on clk
// Notes: Read side effects act at the first access edge, with data capture
`include "usir_params.svh"

module usir_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`USIR_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire usir_pkg::usir_rx_ev_t rx_ev,
   input wire logic [7:0] rx_data,
   input wire usir_pkg::usir_tx_st_t tx_st,
   output logic [7:0] tx_data,
   output logic tx_load,
   input wire logic call_alert_in,
   input wire logic carrier_detect,
   input wire logic hangup_strap,
   output usir_pkg::usir_mctl_t modem_ctl,
   output logic command_state_req,
   output logic irq_out,
   output logic irq_oe_n
);
   // Bus phase strobes
   wire rd_stb;
   wire wr_stb;
   wire first_acc;

   // Address decode
   wire sel_data;
   wire sel_ier;
   wire sel_iir;
   wire sel_mcr;
   wire sel_lsr;
   wire sel_msr;
   wire mapped;

   // Service actions
   wire rbr_read;
   wire thr_write;
   wire lsr_read;
   wire lsr_write;
   wire msr_read;
   wire iir_read;

   // Register contents
   logic [3:0] ier;
   logic [4:0] mcr;
   logic [2:0] iir_id;
   logic [7:0] lsr_val;
   logic [7:0] msr_val;
   logic [7:0] rd_mux;

   // Status flags
   logic dr;
   logic oe;
   logic pe;
   logic fe;
   logic bi;
   logic tx_hold_empty;
   logic tx_shift_empty;
   logic next_tx_shift_empty;
   logic tx_hold_empty_pend;
   logic ring_trailing_edge;
   logic dcd_chg;

   // Synchronised modem inputs
   logic [2:0] pins_s;
   wire ring_s;
   wire dcd_s;
   wire strap_s;
   logic ring_d;
   logic dcd_d;

   // Interrupt sources
   wire src_rls;
   wire src_rda;
   wire src_tx_hold_empty;
   wire src_ms;
   logic [2:0] next_id;

   // Bus phase strobes
   assign first_acc = psel & penable & ~pready;
   assign rd_stb = first_acc & ~pwrite;
   assign wr_stb = psel & penable & pready & pwrite;

   // Address decode
   assign sel_data = (paddr == `USIR_OFF_DATA);
   assign sel_ier = (paddr == `USIR_OFF_IER);
   assign sel_iir = (paddr == `USIR_OFF_IIR);
   assign sel_mcr = (paddr == `USIR_OFF_MCR);
   assign sel_lsr = (paddr == `USIR_OFF_LSR);
   assign sel_msr = (paddr == `USIR_OFF_MSR);
   assign mapped = sel_data | sel_ier | sel_iir | sel_mcr | sel_lsr | sel_msr;

   // Service actions seen by the flags
   assign rbr_read = rd_stb & sel_data;
   assign thr_write = wr_stb & sel_data;
   assign lsr_read = rd_stb & sel_lsr;
   assign lsr_write = wr_stb & sel_lsr;
   assign msr_read = rd_stb & sel_msr;
   assign iir_read = rd_stb & sel_iir;

   // One wait state; ready and error come from flops
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= first_acc;
         pslverr <= first_acc & ~mapped;
      end
   end

   // Read data captured at the first access edge
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         prdata <= 32'h0000_0000;
      else if (rd_stb)
         prdata <= {24'h00_0000, rd_mux};
   end

   // Read data selection
   always_comb
   begin
      rd_mux = 8'h00;
      unique case (1'b1)
         sel_data: rd_mux = rx_data;
         sel_ier: rd_mux = {4'h0, ier};
         sel_iir: rd_mux = {5'h00, iir_id};
         sel_mcr: rd_mux = {3'h0, mcr};
         sel_lsr: rd_mux = lsr_val;
         sel_msr: rd_mux = msr_val;
         default: rd_mux = 8'h00;
      endcase
   end

   // Enable and modem control registers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ier <= `USIR_IER_RST;
         mcr <= `USIR_MCR_RST;
      end
      else
      begin
         if (wr_stb & sel_ier)
            ier <= pwdata[3:0];
         if (wr_stb & sel_mcr)
            mcr <= pwdata[4:0];
      end
   end

   // Holding register write passes the character on
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tx_data <= 8'h00;
         tx_load <= 1'b0;
      end
      else
      begin
         tx_load <= thr_write;
         if (thr_write)
            tx_data <= pwdata[7:0];
      end
   end

   // Receive-ready flag
   usir_flag u_dr (
      .clk(clk),
      .rst(rst),
      .set(rx_ev.load),
      .clr(rbr_read | (lsr_write & ~pwdata[`USIR_LSR_DR])),
      .q(dr)
   );

   // Overrun: new character while the previous one is unread
   usir_flag u_oe (
      .clk(clk),
      .rst(rst),
      .set(rx_ev.load & dr & ~rbr_read),
      .clr(lsr_read),
      .q(oe)
   );

   // Parity fault
   usir_flag u_pe (
      .clk(clk),
      .rst(rst),
      .set(rx_ev.parity_bad),
      .clr(lsr_read),
      .q(pe)
   );

   // Framing fault, cleared with the other errors on a status read
   usir_flag u_fe (
      .clk(clk),
      .rst(rst),
      .set(rx_ev.stop_zero),
      .clr(lsr_read),
      .q(fe)
   );

   // Break seen
   usir_flag u_bi (
      .clk(clk),
      .rst(rst),
      .set(rx_ev.brk),
      .clr(lsr_read),
      .q(bi)
   );

   // Holding register empty; reset shows empty
   usir_flag #(.RST_VAL(1'b1)) u_tx_hold_empty (
      .clk(clk),
      .rst(rst),
      .set(tx_st.hold_to_shift),
      .clr(thr_write),
      .q(tx_hold_empty)
   );

   // Hold-empty interrupt request, also served by an ID read reporting it
   usir_flag u_tx_hold_empty_pend (
      .clk(clk),
      .rst(rst),
      .set(tx_st.hold_to_shift),
      .clr(thr_write | (iir_read & (iir_id == `USIR_ID_TX_HOLD_EMPTY))),
      .q(tx_hold_empty_pend)
   );

   // Shift register empty: a transfer makes it busy
   assign next_tx_shift_empty = tx_st.hold_to_shift ? 1'b0 : (tx_st.shift_idle ? 1'b1 : tx_shift_empty);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         tx_shift_empty <= 1'b1;
      else
         tx_shift_empty <= next_tx_shift_empty;
   end

   // Line status image, top bit tied low
   assign lsr_val = {1'b0, tx_shift_empty, tx_hold_empty, bi, fe, pe, oe, dr};

   // Modem pins and strap through the synchroniser
   usir_sync #(.W(3)) u_sync (
      .clk(clk),
      .rst(rst),
      .d({hangup_strap, carrier_detect, call_alert_in}),
      .q(pins_s)
   );

   assign ring_s = pins_s[0];
   assign dcd_s = pins_s[1];
   assign strap_s = pins_s[2];

   // Previous levels for change detection
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ring_d <= 1'b0;
         dcd_d <= 1'b0;
      end
      else
      begin
         ring_d <= ring_s;
         dcd_d <= dcd_s;
      end
   end

   // Ring trailing edge
   usir_flag u_ring_trailing_edge (
      .clk(clk),
      .rst(rst),
      .set(ring_d & ~ring_s),
      .clr(msr_read),
      .q(ring_trailing_edge)
   );

   // Carrier change
   usir_flag u_dcdc (
      .clk(clk),
      .rst(rst),
      .set(dcd_d ^ dcd_s),
      .clr(msr_read),
      .q(dcd_chg)
   );

   // Modem status image
   assign msr_val = {dcd_s, ~ring_s, `USIR_MSR_ONES, dcd_chg, ring_trailing_edge, 2'h0};

   // Enabled interrupt sources
   assign src_rls = ier[`USIR_IER_RLS] & (oe | pe | fe | bi);
   assign src_rda = ier[`USIR_IER_RDA] & dr;
   assign src_tx_hold_empty = ier[`USIR_IER_TX_HOLD_EMPTY] & tx_hold_empty_pend;
   assign src_ms = ier[`USIR_IER_MS] & (ring_trailing_edge | dcd_chg);

   // Highest pending source; nothing enabled reads as none
   always_comb
   begin
      next_id = `USIR_ID_NONE;
      if (src_rls)
         next_id = `USIR_ID_RLS;
      else if (src_rda)
         next_id = `USIR_ID_RDA;
      else if (src_tx_hold_empty)
         next_id = `USIR_ID_TX_HOLD_EMPTY;
      else if (src_ms)
         next_id = `USIR_ID_MS;
   end

   // Identification held while the register is addressed
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         iir_id <= `USIR_ID_NONE;
      else if (!(psel & sel_iir))
         iir_id <= next_id;
   end

   // Interrupt pin and its drive gate
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         irq_out <= 1'b0;
         irq_oe_n <= 1'b1;
      end
      else
      begin
         irq_out <= ~next_id[0];
         irq_oe_n <= ~mcr[`USIR_MCR_AUX2];
      end
   end

   // Modem control outputs and command-state request
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         modem_ctl <= '0;
         command_state_req <= 1'b0;
      end
      else
      begin
         modem_ctl.terminal_ready <= mcr[`USIR_MCR_DTR];
         modem_ctl.send_request <= mcr[`USIR_MCR_RTS];
         modem_ctl.aux1 <= mcr[`USIR_MCR_AUX1];
         modem_ctl.aux2 <= mcr[`USIR_MCR_AUX2];
         command_state_req <= strap_s & ~mcr[`USIR_MCR_DTR];
      end
   end

endmodule // usir_top

// ---- testbench/usir_chk.sv ----
// Purpose: Port-level checks of the status and interrupt register block
// Assumes: Bound to usir_top; APB reads complete with pready
// Notes: Offsets come from usir_params.svh
`include "usir_params.svh"

module usir_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`USIR_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic [7:0] tx_data,
   input wire logic tx_load,
   input wire usir_pkg::usir_mctl_t modem_ctl,
   input wire logic command_state_req,
   input wire logic irq_oe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // Completing read and write accesses
   wire logic rd_done = psel && penable && pready && !pwrite;
   wire logic wr_done = psel && penable && pready && pwrite;

   AST_PIN_FLOAT: assert property (irq_oe_n == !modem_ctl.aux2)
      else $error("interrupt pin enable disagrees with control bit 3");
   AST_CMD_STATE: assert property (command_state_req |-> !modem_ctl.terminal_ready)
      else $error("command state requested while terminal ready is high");
   AST_ID_TOP: assert property (rd_done && paddr == `USIR_OFF_IIR |-> prdata[31:3] == '0)
      else $error("identification upper bits not zero");
   AST_LSR_TOP: assert property (rd_done && paddr == `USIR_OFF_LSR |-> prdata[31:7] == '0)
      else $error("line status bit 7 not zero");
   AST_MSR_FIXED: assert property (rd_done && paddr == `USIR_OFF_MSR |->
      prdata[5:4] == 2'h3 && prdata[1:0] == 2'h0)
      else $error("modem status fixed bits wrong");
   AST_IER_TOP: assert property (rd_done && paddr == `USIR_OFF_IER |-> prdata[31:4] == '0)
      else $error("enable upper bits not zero");
   AST_MCR_TOP: assert property (rd_done && paddr == `USIR_OFF_MCR |-> prdata[31:5] == '0)
      else $error("modem control bits 7 to 5 not zero");
   AST_HOLD_LOAD: assert property (wr_done && paddr == `USIR_OFF_DATA |=>
      tx_load && {24'h0, tx_data} == ($past(pwdata) & 32'hff))
      else $error("holding register write not passed on");
endmodule // usir_chk

bind usir_top usir_chk i_usir_chk (.*);

// ---- testbench/usir_host.sv ----
// Purpose: APB host model that drives the register side
// Assumes: Tasks are entered just after a rising clk edge
// Notes: One idle cycle follows every transfer
`include "usir_params.svh"

module usir_host (
   input wire logic clk,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [`USIR_AW-1:0] paddr,
   output logic [31:0] pwdata
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle bus at time zero
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
   end

   // One transfer; request held until pready is seen at a rising edge
   task automatic xfer(input logic w, input logic [`USIR_AW-1:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;  // Released data does not keep its last value
      @(posedge clk);
   endtask
endmodule // usir_host

// ---- testbench/tb_uart_status_interrupt_regs.sv ----
// Purpose: Self-checking bench of the status and interrupt register block
// Assumes: usir_host drives APB; pins settle within eight cycles
// Notes: Random rounds pick enables and pending sources
`include "usir_params.svh"

module tb_uart_status_interrupt_regs;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, tx_load, irq_out, irq_oe_n, e;
   logic command_state_req;
   logic [`USIR_AW-1:0] paddr;
   logic [31:0] pwdata, prdata, q, v, x;
   logic [7:0] tx_data;
   logic [7:0] rx_data = 8'h00;
   usir_pkg::usir_rx_ev_t rx_ev = '0;
   usir_pkg::usir_tx_st_t tx_st = 2'h1;
   usir_pkg::usir_mctl_t modem_ctl;
   logic call_alert_in = 1'b1;
   logic carrier_detect = 1'b0;
   logic hangup_strap = 1'b1;
   int n_errors = 0;
   int comparisons = 0;

   usir_top i_usir_top (.*);
   usir_host i_usir_host (.*);

   // Free-running clock, 50 ns period
   always #25 clk = ~clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Register read compared under a mask
   task automatic rdc(input logic [`USIR_AW-1:0] a, input logic [31:0] m, input logic [31:0] y);
      i_usir_host.xfer(1'b0, a, 32'h0, q, e);
      chk(q & m, y);
   endtask

   task automatic wr(input logic [`USIR_AW-1:0] a, input logic [31:0] d);
      i_usir_host.xfer(1'b1, a, d, q, e);
   endtask

   // Receive event and hold-to-shift pulses, then settle
   task automatic pulse(input logic [3:0] r, input logic h);
      rx_ev <= r;
      tx_st.hold_to_shift <= h;
      @(posedge clk);
      rx_ev <= '0;
      tx_st.hold_to_shift <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   // Highest enabled pending source
   function automatic logic [31:0] exp_id(logic [3:0] en, logic ls, logic rd, logic th, logic ms);
      if (en[2] && ls) return 32'h06;
      if (en[0] && rd) return 32'h04;
      if (en[1] && th) return 32'h02;
      if (en[3] && ms) return 32'h00;
      return 32'h01;
   endfunction

   task automatic end_of_test();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial
   begin
      repeat (20000) @(posedge clk);
      n_errors++;
      $display("BAD t=%0t watchdog expired", $time);
      end_of_test();
   end

   // Main sequence
   initial
   begin
      v = $urandom(40438);
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rdc(`USIR_OFF_LSR, 32'hff, 32'h60);
      rdc(`USIR_OFF_IIR, 32'hff, 32'h01);
      rdc(`USIR_OFF_IER, 32'hff, 32'h00);
      rdc(`USIR_OFF_MSR, 32'hff, 32'h30);
      wr(`USIR_OFF_MCR, 32'hff);
      rdc(`USIR_OFF_MCR, 32'hef, 32'h0f);
      @(negedge clk);
      chk({27'h0, modem_ctl, irq_oe_n}, 32'h1e);
      @(posedge clk);
      wr(`USIR_OFF_MCR, 32'h00);
      @(negedge clk);
      chk({30'h0, command_state_req, irq_oe_n}, 32'h3);
      @(posedge clk);
      wr(`USIR_OFF_MCR, 32'h08);
      // Line errors with all enables off
      pulse(4'h8, 1'b0);
      pulse(4'hb, 1'b0);
      rdc(`USIR_OFF_IIR, 32'hff, 32'h01);
      chk({31'h0, irq_out}, 32'h0);
      rdc(`USIR_OFF_LSR, 32'h1f, 32'h1b);
      rdc(`USIR_OFF_LSR, 32'h1f, 32'h01);
      wr(`USIR_OFF_LSR, 32'h00);
      rdc(`USIR_OFF_LSR, 32'h01, 32'h00);
      i_usir_host.xfer(1'b0, 5'h1c, 32'h0, q, e);
      chk({e, q[30:0]}, 32'h80000000);
      // Ring trailing edge
      wr(`USIR_OFF_IER, 32'hff);
      call_alert_in <= 1'b0;
      repeat (8) @(posedge clk);
      rdc(`USIR_OFF_IIR, 32'hff, 32'h00);
      rdc(`USIR_OFF_MSR, 32'hff, 32'h74);
      rdc(`USIR_OFF_MSR, 32'hff, 32'h70);
      wr(`USIR_OFF_DATA, 32'h00);
      repeat (16)
      begin
         v = $urandom;
         wr(`USIR_OFF_IER, v);
         rx_data <= v[15:8];
         pulse({v[4], v[5], 2'b00}, v[6]);
         carrier_detect <= carrier_detect ^ v[7];
         repeat (8) @(posedge clk);
         x = exp_id(v[3:0], v[5], v[4], v[6], v[7]);
         chk({31'h0, irq_out}, {31'h0, x != 32'h01});
         rdc(`USIR_OFF_IIR, 32'hff, x);
         rdc(`USIR_OFF_IIR, 32'hff, exp_id(v[3:0], v[5], v[4], v[6] & (x != 32'h02), v[7]));
         rdc(`USIR_OFF_LSR, 32'h3e, {26'h0, v[6], 2'h0, v[5], 2'h0});
         rdc(`USIR_OFF_DATA, 32'hff, {24'h0, v[15:8]});
         rdc(`USIR_OFF_MSR, 32'h88, {24'h0, carrier_detect, 3'h0, v[7], 3'h0});
         wr(`USIR_OFF_DATA, {24'h0, v[23:16]});
         rdc(`USIR_OFF_IIR, 32'hff, 32'h01);
         chk({24'h0, tx_data}, {24'h0, v[23:16]});
      end
      end_of_test();
   end
endmodule // tb_uart_status_interrupt_regs
